/* File: core/urs_pkg.sv */
// Shared constants and types of the receive status flag block.
// Assumes a 32-bit Avalon-MM register bus and a receiver on the same clock.
package urs_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses, one 32-bit word each)
   // ---------------------------------------------------------------
   localparam logic [4:0] URS_OFS_STATUS     = 5'h00;
   localparam logic [4:0] URS_OFS_FIFO_CTRL  = 5'h04;
   localparam logic [4:0] URS_OFS_FILL_COUNT = 5'h08;
   localparam logic [4:0] URS_OFS_RX_PORT    = 5'h0C;
   localparam logic [4:0] URS_OFS_IRQ_STATUS = 5'h10;
   localparam logic [4:0] URS_OFS_IRQ_MASK   = 5'h14;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   // Status word
   localparam int URS_BIT_IDLE   = 0;
   localparam int URS_BIT_THRESH = 1;
   localparam int URS_BIT_PARITY = 2;
   // Fifo control word: two trigger select bits
   localparam int URS_BIT_TRG_LO = 6;
   localparam int URS_BIT_TRG_HI = 7;
   // Fill count word: receive count in the low byte
   localparam int URS_FILL_LSB   = 0;
   localparam int URS_FILL_W     = 8;

   // ---------------------------------------------------------------
   // Sizes, reset values and timing
   // ---------------------------------------------------------------
   localparam int          URS_FIFO_DEPTH  = 16;
   localparam int          URS_CNT_W       = 5;
   localparam int          URS_EVT_W       = 3;
   localparam logic [3:0]  URS_IDLE_ETU    = 4'hF;
   localparam logic [1:0]  URS_TRG_RESET   = 2'h0;
   localparam logic [2:0]  URS_EVT_RESET   = 3'h0;
   localparam logic [31:0] URS_WORD_ZERO   = 32'h0000_0000;

   // Trigger numbers picked by the two select bits
   localparam logic [URS_CNT_W-1:0] URS_TRG_NUM0 = 5'h01;
   localparam logic [URS_CNT_W-1:0] URS_TRG_NUM1 = 5'h04;
   localparam logic [URS_CNT_W-1:0] URS_TRG_NUM2 = 5'h08;
   localparam logic [URS_CNT_W-1:0] URS_TRG_NUM3 = 5'h0E;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   // What the receiver and its fifo show this block
   typedef struct packed {
      logic                 async_mode;
      logic                 etu_tick;
      logic                 char_start;
      logic                 stop_end;
      logic                 head_parity_err;
      logic [7:0]           head_data;
      logic [URS_CNT_W-1:0] fill_count;
   } urs_rx_obs_type;

   typedef enum logic [1:0] {
      URS_BUS_IDLE,
      URS_BUS_ANSWER
   } urs_bus_state_type;

endpackage

/* File: core/urs_idle_timer.sv */
// Counts elementary time units after a stop bit and flags an idle line.
// Assumes one etu_tick pulse per bit period from the receiver's timing.
`timescale 1ns/1ps
module urs_idle_timer
   import urs_pkg::*;
(
   input  wire logic mclk,
   input  wire logic srst,
   input  wire logic stop_end,
   input  wire logic char_start,
   input  wire logic etu_tick,
   output logic      expired
);

   logic [3:0] etu_q;
   logic       run_q;

   // ---------------------------------------------------------------
   // Unit counter
   // ---------------------------------------------------------------
   // A new start bit cancels the wait; a stop bit restarts it
   always_ff @(posedge mclk) begin
      if (srst) begin
         run_q <= 1'b0;
         etu_q <= 4'h0;
      end else if (char_start) begin
         run_q <= 1'b0;
         etu_q <= 4'h0;
      end else if (stop_end) begin
         run_q <= 1'b1;
         etu_q <= 4'h0;
      end else if (run_q && etu_tick) begin
         etu_q <= etu_q + 4'h1;
         if (etu_q + 4'h1 == URS_IDLE_ETU) begin
            run_q <= 1'b0;
         end
      end
   end

   // One pulse per silent gap
   always_comb begin
      expired = run_q && etu_tick && !char_start && !stop_end
                && (etu_q + 4'h1 == URS_IDLE_ETU);
   end

endmodule

/* File: core/urs_clear_flag.sv */
// One hardware-set flag cleared by read-one, write-zero, then a condition.
// Assumes one-cycle read and write pulses from the register slave.
`timescale 1ns/1ps
module urs_clear_flag (
   input  wire logic mclk,
   input  wire logic srst,
   input  wire logic set_cond,
   input  wire logic read_seen,
   input  wire logic write_zero,
   input  wire logic clear_cond,
   output logic      flag_q
);

   logic seen_q;
   logic armed_q;

   // ---------------------------------------------------------------
   // Clear sequence
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         seen_q  <= 1'b0;
         armed_q <= 1'b0;
      end else if (!flag_q) begin
         seen_q  <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         if (read_seen) begin
            seen_q <= 1'b1;
         end
         // Writing one leaves both flag and sequence alone
         if (write_zero && seen_q) begin
            armed_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Flag
   // ---------------------------------------------------------------
   // Set wins over a clear that lands in the same cycle
   always_ff @(posedge mclk) begin
      if (srst) begin
         flag_q <= 1'b0;
      end else if (set_cond) begin
         flag_q <= 1'b1;
      end else if (armed_q && clear_cond) begin
         flag_q <= 1'b0;
      end
   end

endmodule

/* File: core/urs_rx_status.sv */
// Receive status flags: parity of the fifo head, threshold and idle.
// Assumes the fifo storage and the receiver sit outside on mclk and
// pop one entry per rx_pop pulse.
`timescale 1ns/1ps

// What this block does
// - Async mode: parity flag follows head entry error
// - Parity flag drops when head entry clean
// - Reset clears parity, threshold and idle flags
// - Threshold flag sets when count exceeds trigger
// - Threshold clears: read one, write zero, drain
// - Fifo holds sixteen; over-read returns undefined
// - Fill count register low byte shows count
// - Async: idle after fifteen units, below trigger
// - Clock-synchronous mode never sets idle flag
// - Idle clears: read one, write zero, empty
// - Only zero writes clear status flags; one is ignored
module urs_rx_status
   import urs_pkg::*;
(
   input  wire logic           mclk,
   input  wire logic           srst,
   // Avalon-MM slave
   input  wire logic [4:0]     address,
   input  wire logic           read,
   input  wire logic           write,
   input  wire logic [3:0]     byteenable,
   input  wire logic [31:0]    writedata,
   output logic      [31:0]    readdata,
   output logic                waitrequest,
   // Receiver and fifo observation
   input  wire urs_rx_obs_type rx_obs,
   output logic                rx_pop,
   // Flags and interrupt
   output logic                parity_error_flag,
   output logic                rx_threshold_flag,
   output logic                rx_idle_timeout_flag,
   output logic                irq
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   urs_bus_state_type     bus_q;
   logic [31:0]           rdata_q;
   logic [1:0]            trg_sel_q;
   logic                  parity_q;
   logic                  thresh_flag;
   logic                  idle_flag;
   logic [URS_EVT_W-1:0]  evt_q;
   logic [URS_EVT_W-1:0]  evt_d;
   logic [URS_EVT_W-1:0]  mask_q;
   logic [URS_EVT_W-1:0]  flags_now;
   logic [URS_EVT_W-1:0]  flags_prev_q;
   logic [URS_CNT_W-1:0]  trig_num;
   logic [URS_CNT_W-1:0]  fill;
   logic                  req;
   logic                  acc_rd;
   logic                  acc_wr;
   logic                  wr_lo;
   logic                  status_rd;
   logic                  status_wr;
   logic                  thresh_set;
   logic                  thresh_clr;
   logic                  idle_set;
   logic                  idle_clr;
   logic                  idle_expired;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [URS_CNT_W-1:0] trig_lookup(
      input logic [1:0] sel
   );
      logic [URS_CNT_W-1:0] n;
      n = URS_TRG_NUM0;
      case (sel)
         2'h0: n = URS_TRG_NUM0;
         2'h1: n = URS_TRG_NUM1;
         2'h2: n = URS_TRG_NUM2;
         2'h3: n = URS_TRG_NUM3;
         default: n = URS_TRG_NUM0;
      endcase
      return n;
   endfunction

   function automatic logic hit(
      input logic [4:0] addr,
      input logic [4:0] ofs
   );
      return addr == ofs;
   endfunction

   // ---------------------------------------------------------------
   // Bus handshake
   // ---------------------------------------------------------------
   // Every access waits one cycle, so read data are always registered
   // and side effects happen exactly once, at the accepting edge.
   assign req         = read || write;
   assign waitrequest = req && (bus_q != URS_BUS_ANSWER);
   assign acc_rd      = read && (bus_q == URS_BUS_ANSWER);
   assign acc_wr      = write && (bus_q == URS_BUS_ANSWER);
   assign wr_lo       = acc_wr && byteenable[0];
   assign readdata    = rdata_q;

   always_ff @(posedge mclk) begin
      if (srst) begin
         bus_q <= URS_BUS_IDLE;
      end else begin
         case (bus_q)
            URS_BUS_IDLE: begin
               if (req) begin
                  bus_q <= URS_BUS_ANSWER;
               end
            end
            URS_BUS_ANSWER: begin
               bus_q <= URS_BUS_IDLE;
            end
            default: begin
               bus_q <= URS_BUS_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   // Captured in the wait cycle; unmapped addresses read as zero.
   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata_q <= URS_WORD_ZERO;
      end else if (read && bus_q == URS_BUS_IDLE) begin
         rdata_q <= URS_WORD_ZERO;
         if (hit(address, URS_OFS_STATUS)) begin
            rdata_q[URS_BIT_PARITY] <= parity_q;
            rdata_q[URS_BIT_THRESH] <= thresh_flag;
            rdata_q[URS_BIT_IDLE]   <= idle_flag;
         end else if (hit(address, URS_OFS_FIFO_CTRL)) begin
            rdata_q[URS_BIT_TRG_HI] <= trg_sel_q[1];
            rdata_q[URS_BIT_TRG_LO] <= trg_sel_q[0];
         end else if (hit(address, URS_OFS_FILL_COUNT)) begin
            rdata_q[URS_FILL_LSB +: URS_FILL_W] <=
               URS_FILL_W'(fill);
         end else if (hit(address, URS_OFS_RX_PORT)) begin
            // An empty fifo gives whatever the storage shows
            rdata_q[7:0] <= rx_obs.head_data;
         end else if (hit(address, URS_OFS_IRQ_STATUS)) begin
            rdata_q[URS_EVT_W-1:0] <= evt_q;
         end else if (hit(address, URS_OFS_IRQ_MASK)) begin
            rdata_q[URS_EVT_W-1:0] <= mask_q;
         end
      end
   end

   // ---------------------------------------------------------------
   // Fifo control and receive port
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         trg_sel_q <= URS_TRG_RESET;
      end else if (wr_lo && hit(address, URS_OFS_FIFO_CTRL)) begin
         trg_sel_q <= {writedata[URS_BIT_TRG_HI],
                       writedata[URS_BIT_TRG_LO]};
      end
   end

   assign trig_num = trig_lookup(trg_sel_q);
   assign fill     = rx_obs.fill_count;

   // Pop only on a real entry; reading past empty has no effect
   always_ff @(posedge mclk) begin
      if (srst) begin
         rx_pop <= 1'b0;
      end else begin
         rx_pop <= acc_rd && hit(address, URS_OFS_RX_PORT)
                   && (fill != '0);
      end
   end

   // ---------------------------------------------------------------
   // Parity of the head entry
   // ---------------------------------------------------------------
   // Read-only: it follows whichever entry would be read next.
   always_ff @(posedge mclk) begin
      if (srst) begin
         parity_q <= 1'b0;
      end else begin
         parity_q <= rx_obs.async_mode
                     && rx_obs.head_parity_err
                     && (fill != '0);
      end
   end

   // ---------------------------------------------------------------
   // Threshold flag
   // ---------------------------------------------------------------
   assign status_rd = acc_rd && hit(address, URS_OFS_STATUS);
   assign status_wr = wr_lo && hit(address, URS_OFS_STATUS);

   assign thresh_set = fill > trig_num;
   assign thresh_clr = fill < trig_num;

   urs_clear_flag u_thresh (
      .mclk       (mclk),
      .srst       (srst),
      .set_cond   (thresh_set),
      .read_seen  (status_rd && thresh_flag),
      .write_zero (status_wr && !writedata[URS_BIT_THRESH]),
      .clear_cond (thresh_clr),
      .flag_q     (thresh_flag)
   );

   // ---------------------------------------------------------------
   // Idle timeout flag
   // ---------------------------------------------------------------
   urs_idle_timer u_idle_timer (
      .mclk       (mclk),
      .srst       (srst),
      .stop_end   (rx_obs.stop_end),
      .char_start (rx_obs.char_start),
      .etu_tick   (rx_obs.etu_tick),
      .expired    (idle_expired)
   );

   // Raised only with data left over and below the trigger number
   assign idle_set = idle_expired
                     && rx_obs.async_mode
                     && (fill < trig_num)
                     && (fill != '0);
   assign idle_clr = fill == '0;

   urs_clear_flag u_idle (
      .mclk       (mclk),
      .srst       (srst),
      .set_cond   (idle_set),
      .read_seen  (status_rd && idle_flag),
      .write_zero (status_wr && !writedata[URS_BIT_IDLE]),
      .clear_cond (idle_clr),
      .flag_q     (idle_flag)
   );

   assign parity_error_flag    = parity_q;
   assign rx_threshold_flag    = thresh_flag;
   assign rx_idle_timeout_flag = idle_flag;

   // ---------------------------------------------------------------
   // Interrupt events
   // ---------------------------------------------------------------
   // Rising edges of the three flags are the events; a new event in
   // the clearing cycle survives the write-one clear.
   always_comb begin
      flags_now = '0;
      flags_now[URS_BIT_IDLE]   = idle_flag;
      flags_now[URS_BIT_THRESH] = thresh_flag;
      flags_now[URS_BIT_PARITY] = parity_q;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         flags_prev_q <= URS_EVT_RESET;
      end else begin
         flags_prev_q <= flags_now;
      end
   end

   always_comb begin
      evt_d = evt_q;
      if (wr_lo && hit(address, URS_OFS_IRQ_STATUS)) begin
         evt_d = evt_q & ~writedata[URS_EVT_W-1:0];
      end
      evt_d = evt_d | (flags_now & ~flags_prev_q);
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         evt_q <= URS_EVT_RESET;
      end else begin
         evt_q <= evt_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         mask_q <= URS_EVT_RESET;
      end else if (wr_lo && hit(address, URS_OFS_IRQ_MASK)) begin
         mask_q <= writedata[URS_EVT_W-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(evt_d & mask_q);
      end
   end

endmodule

/* File: sim/urs_rx_status_asserts.sv */
// Checker for the receive status flag block, bound to its top module.
// Assumes a single mclk domain and a master that holds each request.
`timescale 1ns/1ps
module urs_rx_status_asserts
   import urs_pkg::*;
(
   input wire logic           mclk,
   input wire logic           srst,
   input wire logic [4:0]     address,
   input wire logic           read,
   input wire logic           write,
   input wire logic [3:0]     byteenable,
   input wire logic [31:0]    writedata,
   input wire logic [31:0]    readdata,
   input wire logic           waitrequest,
   input wire urs_rx_obs_type rx_obs,
   input wire logic           rx_pop,
   input wire logic           parity_error_flag,
   input wire logic           rx_threshold_flag,
   input wire logic           rx_idle_timeout_flag,
   input wire logic           irq
);
   // ---------------------------------------------------------------
   // Shadow of the trigger selection
   // ---------------------------------------------------------------
   logic [1:0]           sel_q;
   logic [URS_CNT_W-1:0] trg;
   logic                 port_acc;
   logic                 par_c;
   logic                 idle_ok;
   always_ff @(posedge mclk) begin
      if (srst)
         sel_q <= URS_TRG_RESET;
      else if (write && !waitrequest && byteenable[0] &&
               address == URS_OFS_FIFO_CTRL)
         sel_q <= writedata[URS_BIT_TRG_HI:URS_BIT_TRG_LO];
   end
   always_comb begin
      case (sel_q)
         2'h0: trg = URS_TRG_NUM0;
         2'h1: trg = URS_TRG_NUM1;
         2'h2: trg = URS_TRG_NUM2;
         default: trg = URS_TRG_NUM3;
      endcase
   end
   assign port_acc = read && !waitrequest && address == URS_OFS_RX_PORT;
   assign par_c = rx_obs.async_mode && rx_obs.head_parity_err &&
                  rx_obs.fill_count != 5'h00;
   assign idle_ok = rx_obs.fill_count != 5'h00 && rx_obs.fill_count < trg;

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   wait_one_a: assert property ((read || write) && waitrequest |=>
      !waitrequest) else $error("bus answer not after one wait cycle");
   pop_after_a: assert property (port_acc && rx_obs.fill_count != 5'h00 |=>
      rx_pop) else $error("no pop after a port read");
   pop_cause_a: assert property (rx_pop |-> $past(port_acc))
      else $error("pop without a port read");
   parity_track_a: assert property (!$past(srst) |->
      parity_error_flag == $past(par_c)) else $error("parity flag wrong");
   thresh_set_a: assert property (rx_obs.fill_count > trg |-> ##[1:2]
      rx_threshold_flag) else $error("threshold flag not set");
   thresh_hold_a: assert property (rx_threshold_flag &&
      rx_obs.fill_count >= trg |=> rx_threshold_flag)
      else $error("threshold flag cleared early");
   idle_sync_a: assert property ($rose(rx_idle_timeout_flag) |->
      $past(rx_obs.async_mode)) else $error("idle flag in sync mode");
   idle_cond_a: assert property ($rose(rx_idle_timeout_flag) |->
      $past(idle_ok)) else $error("idle flag with wrong fill");
   idle_hold_a: assert property (rx_idle_timeout_flag &&
      rx_obs.fill_count != 5'h00 |=> rx_idle_timeout_flag)
      else $error("idle flag cleared with data left");
   reset_clear_a: assert property (disable iff (1'b0) srst |=>
      !parity_error_flag && !rx_threshold_flag && !rx_idle_timeout_flag &&
      !irq) else $error("flags not cleared by reset");

   cover property ($rose(rx_threshold_flag));
   cover property ($rose(rx_idle_timeout_flag));
   cover property (rx_pop && parity_error_flag);
endmodule

bind urs_rx_status urs_rx_status_asserts urs_rx_status_asserts_i (
   .mclk, .srst, .address, .read, .write, .byteenable, .writedata,
   .readdata, .waitrequest, .rx_obs, .rx_pop, .parity_error_flag,
   .rx_threshold_flag, .rx_idle_timeout_flag, .irq);

/* File: sim/urs_far_rx.sv */
// Behavioural far side: serial receiver and its sixteen-entry fifo.
// Assumes the bench pulses send once per character, on mclk.
`timescale 1ns/1ps
module urs_far_rx
   import urs_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       srst,
   input  wire logic       async_mode,
   input  wire logic       send,
   input  wire logic [7:0] send_data,
   input  wire logic       send_perr,
   input  wire logic       rx_pop,
   output urs_rx_obs_type  rx_obs
);
   logic [8:0] q [$];
   logic [1:0] div_q;
   logic       stop_q;
   logic [7:0] last_q;
   // Sole driver of rx_obs; it is unknown only until the second edge,
   // while reset still holds the block.
   always @(posedge mclk) begin
      if (srst) begin
         q.delete();
         div_q  <= 2'h0;
         stop_q <= 1'b0;
         last_q <= 8'h00;
      end else begin
         div_q  <= div_q + 2'h1;
         stop_q <= send;
         if (rx_pop && q.size() != 0) begin
            last_q <= q[0][7:0];
            void'(q.pop_front());
         end
         if (send && q.size() < URS_FIFO_DEPTH)
            q.push_back({send_perr, send_data});
      end
      rx_obs.async_mode <= async_mode;
      rx_obs.etu_tick   <= !srst && div_q == 2'h3;
      rx_obs.char_start <= send;
      rx_obs.stop_end   <= stop_q;
      rx_obs.fill_count <= 5'(q.size());
      // Empty fifo shows garbage, never a stale head
      rx_obs.head_parity_err <= q.size() != 0 ? q[0][8] : 1'b1;
      rx_obs.head_data <= q.size() != 0 ? q[0][7:0] : ~last_q;
   end
endmodule

/* File: sim/urs_rx_status_bench.sv */
// Self-checking bench of the receive status flag block.
// Assumes the far-side model and checker files are compiled before it.
`timescale 1ns/1ps
module urs_rx_status_bench;
   import urs_pkg::*;
   logic           mclk = 1'b0, srst = 1'b1, read = 1'b0, write = 1'b0;
   logic [4:0]     address = 5'h00;
   logic [3:0]     byteenable = 4'h1;
   logic [31:0]    writedata = 32'h0000_0000, readdata, rd;
   logic           waitrequest, rx_pop, parity_error_flag, irq;
   logic           rx_threshold_flag, rx_idle_timeout_flag;
   logic           async_mode = 1'b0, send = 1'b0, send_perr = 1'b0;
   logic [7:0]     send_data = 8'h00;
   logic [31:0]    seed = 32'h0001_552E;
   urs_rx_obs_type rx_obs;
   logic [8:0]     exp_q [$];
   int             num_errors = 0, num_checks = 0, t;

   always #2 mclk = ~mclk;

   urs_rx_status urs_rx_status_i (.mclk, .srst, .address, .read, .write,
      .byteenable, .writedata, .readdata, .waitrequest, .rx_obs, .rx_pop,
      .parity_error_flag, .rx_threshold_flag, .rx_idle_timeout_flag, .irq);
   urs_far_rx urs_far_rx_i (.mclk, .srst, .async_mode, .send, .send_data,
      .send_perr, .rx_pop, .rx_obs);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   function automatic int trg(input int s);
      case (s)
         0: return URS_TRG_NUM0;
         1: return URS_TRG_NUM1;
         2: return URS_TRG_NUM2;
         default: return URS_TRG_NUM3;
      endcase
   endfunction
   task automatic results;
      if (num_errors == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Latencies of pop, fill and flags settle within three edges
   task automatic settle;
      repeat (3) @(posedge mclk);
   endtask
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] wd);
      int n;
      address <= a;
      writedata <= wd;
      read <= !wr;
      write <= wr;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      rd = readdata;
      if (n >= 50) begin
         num_errors++;
         results();
      end
      read <= 1'b0;
      write <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic reg_rd(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, e);
   endtask
   task automatic push(input logic pe);
      seed = xs(seed);
      send <= 1'b1;
      send_data <= seed[7:0];
      send_perr <= pe;
      @(posedge mclk);
      send <= 1'b0;
      @(posedge mclk);
      exp_q.push_back({pe, seed[7:0]});
   endtask
   task automatic pop;
      chk(parity_error_flag, async_mode ? exp_q[0][8] : 1'b0);
      bus(1'b0, URS_OFS_RX_PORT, 32'h0000_0000);
      chk(rd & 32'h0000_00FF, {24'h00_0000, exp_q[0][7:0]});
      void'(exp_q.pop_front());
      settle;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      chk({parity_error_flag, rx_threshold_flag, rx_idle_timeout_flag}, 0);
      reg_rd(URS_OFS_STATUS, 32'h0000_0000);
      reg_rd(URS_OFS_FIFO_CTRL, 32'h0000_0000);
      reg_rd(5'h18, 32'h0000_0000);
      // A write without the low byte lane must leave the trigger alone
      byteenable <= 4'h0;
      bus(1'b1, URS_OFS_FIFO_CTRL, 32'h0000_00C0);
      byteenable <= 4'h1;
      reg_rd(URS_OFS_FIFO_CTRL, 32'h0000_0000);
      for (int s = 0; s < 4; s++) begin
         t = trg(s);
         bus(1'b1, URS_OFS_IRQ_MASK, 32'h0000_0000);
         bus(1'b1, URS_OFS_FIFO_CTRL, 32'(s) << URS_BIT_TRG_LO);
         repeat (t) push(1'b0);
         settle;
         chk(rx_threshold_flag, 1'b0);
         push(1'b0);
         settle;
         chk(rx_threshold_flag, 1'b1);
         reg_rd(URS_OFS_FILL_COUNT, 32'(t + 1));
         chk(irq, 1'b0);
         bus(1'b1, URS_OFS_IRQ_MASK, 32'h0000_0002);
         settle;
         chk(irq, 1'b1);
         bus(1'b1, URS_OFS_IRQ_STATUS, 32'h0000_0002);
         settle;
         chk(irq, 1'b0);
         reg_rd(URS_OFS_STATUS, 32'h0000_0002);
         bus(1'b1, URS_OFS_STATUS, {30'h0, s[0], 1'b0});
         pop;
         chk(rx_threshold_flag, 1'b1);
         pop;
         chk(rx_threshold_flag, s[0]);
         if (s[0]) begin
            reg_rd(URS_OFS_STATUS, 32'h0000_0002);
            bus(1'b1, URS_OFS_STATUS, 32'h0000_0000);
            settle;
            chk(rx_threshold_flag, 1'b0);
         end
         while (exp_q.size() != 0) pop;
      end
      // Idle timeout in asynchronous mode, trigger of eight
      async_mode <= 1'b1;
      bus(1'b1, URS_OFS_FIFO_CTRL, 32'h0000_0080);
      push(1'b1);
      push(1'b0);
      repeat (3) begin
         seed = xs(seed);
         push(seed[9]);
      end
      repeat (50) @(posedge mclk);
      chk(rx_idle_timeout_flag, 1'b0);
      repeat (18) @(posedge mclk);
      chk(rx_idle_timeout_flag, 1'b1);
      bus(1'b0, URS_OFS_STATUS, 32'h0000_0000);
      chk(rd[URS_BIT_IDLE], 1'b1);
      bus(1'b1, URS_OFS_STATUS, 32'h0000_0000);
      settle;
      chk(rx_idle_timeout_flag, 1'b1);
      while (exp_q.size() != 0) pop;
      chk(rx_idle_timeout_flag, 1'b0);
      // Clock-synchronous mode never reports idle
      async_mode <= 1'b0;
      repeat (3) push(1'b1);
      repeat (80) @(posedge mclk);
      chk(rx_idle_timeout_flag, 1'b0);
      while (exp_q.size() != 0) pop;
      results();
   end
endmodule
